// ---- vib_pkg.sv ----
// Package with register map, field layout and encodings for the VME interface register bank
package vib_pkg;
    localparam int unsigned VIB_LADDR_W     = 24;
    localparam int unsigned VIB_DEV_SEL_BIT = 23;
    localparam int unsigned VIB_DEV_HI      = 23;
    localparam int unsigned VIB_DEV_LO      = 21;
    localparam int unsigned VIB_WORD_W      = 21;
    localparam logic [2:0]  VIB_DEV_SRAM_A0 = 3'h0;
    localparam logic [2:0]  VIB_DEV_SRAM_A1 = 3'h1;
    localparam logic [2:0]  VIB_DEV_SRAM_B0 = 3'h2;
    localparam logic [2:0]  VIB_DEV_SRAM_B1 = 3'h3;

    localparam logic [23:0] VIB_OFF_BUS_REQ    = 24'h800000;
    localparam logic [23:0] VIB_OFF_RESET      = 24'h800004;
    localparam logic [23:0] VIB_OFF_BOOT       = 24'h800008;
    localparam logic [23:0] VIB_OFF_INHIBIT    = 24'h80000C;
    localparam logic [23:0] VIB_OFF_OWNER_A    = 24'h810000;
    localparam logic [23:0] VIB_OFF_OWNER_B    = 24'h810004;
    localparam logic [23:0] VIB_OFF_OWNER_X    = 24'h810008;
    localparam logic [23:0] VIB_OFF_MBX_CLEAR  = 24'h820000;
    localparam logic [23:0] VIB_OFF_LA_IRQ     = 24'h820004;
    localparam logic [23:0] VIB_OFF_SERIAL     = 24'h820048;
    localparam logic [23:0] VIB_OFF_SVC_MBX    = 24'h820824;
    localparam logic [23:0] VIB_OFF_PROC_MBX   = 24'h821048;

    localparam int unsigned VIB_BIT_REQ_A      = 0;
    localparam int unsigned VIB_BIT_REQ_B      = 1;
    localparam int unsigned VIB_BIT_REQ_X      = 16;
    localparam int unsigned VIB_BIT_REQ_PROC_B = 17;
    localparam int unsigned VIB_BIT_RST_LA     = 0;
    localparam int unsigned VIB_BIT_RST_PROC   = 1;
    localparam int unsigned VIB_BIT_IRQ_LA     = 18;
    localparam int unsigned VIB_BIT_IRQ_PROC   = 19;
    localparam int unsigned VIB_BIT_SRAM_BOOT  = 16;
    localparam int unsigned VIB_BIT_INHIBIT    = 0;
    localparam int unsigned VIB_SERIAL_W       = 11;

    localparam logic [1:0]  VIB_RST_RESET      = 2'h3;
    localparam logic [1:0]  VIB_SECTOR_RESET   = 2'h0;
    localparam logic        VIB_SRAM_RESET     = 1'b0;
    localparam logic [3:0]  VIB_REQ_RESET      = 4'h0;
    localparam logic        VIB_INHIBIT_RESET  = 1'b0;

    typedef enum logic [1:0] {
        VIB_OWN_FREE = 2'h0,
        VIB_OWN_HOST = 2'h1,
        VIB_OWN_LA   = 2'h2,
        VIB_OWN_PROC = 2'h3
    } vib_owner_e;
endpackage : vib_pkg

// ---- vib_arb_if.sv ----
// Interface carrying bus requests and owner codes between register bank and arbiter
`timescale 1ns/1ps
`default_nettype none
interface vib_arb_if;
    import vib_pkg::*;
    logic       host_req;
    logic       la_req;
    logic       proc_req;
    logic       proc_req_by_host;
    logic       inhibit;
    vib_owner_e owner;
    modport bank (output host_req, output la_req, output proc_req, output proc_req_by_host,
                  output inhibit, input owner);
    modport arb  (input host_req, input la_req, input proc_req, input proc_req_by_host,
                  input inhibit, output owner);
endinterface : vib_arb_if
`default_nettype wire

// ---- vib_bus_arbiter.sv ----
// Arbiter for one shared internal bus
`timescale 1ns/1ps
`default_nettype none
module vib_bus_arbiter
    import vib_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    vib_arb_if.arb    arb
);
    vib_owner_e owner_q;
    vib_owner_e owner_d;

    always_comb
    begin
        owner_d = owner_q;
        unique case (owner_q)
            VIB_OWN_FREE:
            begin
                // Host first; on-board masters only when not inhibited, except a processor grant requested by the host
                if (arb.host_req)
                    owner_d = VIB_OWN_HOST;
                else if (!arb.inhibit && arb.la_req)
                    owner_d = VIB_OWN_LA;
                else if ((!arb.inhibit && arb.proc_req) || arb.proc_req_by_host)
                    owner_d = VIB_OWN_PROC;
            end
            VIB_OWN_HOST:
                if (!arb.host_req)
                    owner_d = VIB_OWN_FREE;
            VIB_OWN_LA:
                if (!arb.la_req || arb.inhibit)
                    owner_d = VIB_OWN_FREE;
            VIB_OWN_PROC:
                if (!(arb.proc_req_by_host || (arb.proc_req && !arb.inhibit)))
                    owner_d = VIB_OWN_FREE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            owner_q <= VIB_OWN_FREE;
        else
            owner_q <= owner_d;
    end

    assign arb.owner = owner_q;

    a_host_grant_free: assert property (@(posedge clk_i) disable iff (rst_i)
        (owner_q == VIB_OWN_HOST && !arb.host_req) |=> owner_q == VIB_OWN_FREE)
        else $error("host bus not returned to free");
    a_inhibit_blocks_la: assert property (@(posedge clk_i) disable iff (rst_i)
        arb.inhibit |=> owner_q != VIB_OWN_LA)
        else $error("logic array owns bus while inhibited");
endmodule : vib_bus_arbiter
`default_nettype wire

// ---- vib_reg_bank.sv ----
// Register bank, address decode and arbiter instances of the VME interface
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Respond to register access only when local address bit 23 is one.
// - Top three local bits pick internal device; low 21 bits pick word.
// - Register data on D0, D1, D16, D17; selection from A2, A3, A16, A17.
// - Bus request register: bit0 bus A, bit1 B, bit16 X, bit17 B for processor.
// - Each request write updates all request bits together; zero withdraws.
// - Reading request register returns grant status and interrupt flags.
// - Write-only reset register: bit0 logic array, bit1 processor; zero releases.
// - Releasing logic array reset starts configuration from the selected boot source.
// - Boot register read/write: bits 1:0 flash sector, bit16 SRAM bank A.
// - SRAM boot bit overrides the flash sector bits.
// - Writing one to inhibit location stops on-board masters taking any bus, except the processor on bus B when the host requests it (bit17).
// - Writing zero to inhibit lets on-board masters compete again.
// - Three read-only registers report owners of buses A, B, X.
// - Owner code: 0 free, 1 host, 2 logic array, 3 processor.
// - Serial number read-only, 11 bits in data bits 0 to 10.
// - Write to mailbox clear location clears all mailboxes and flags.
// - Writes interrupt logic array or load processor mailbox and interrupt it.
// - Service mailbox is read-only and polled for pending requests.
// - Low windows map onto SRAM bank A and bank B, word offset unchanged.
module vib_reg_bank
    import vib_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  acc_i,
    input  wire logic                  wr_i,
    input  wire logic [VIB_LADDR_W-1:0] addr_i,
    input  wire logic [31:0]           wdata_i,
    output logic      [31:0]           rdata_o,
    output logic                       ack_o,
    input  wire logic [2:0]            la_req_i,
    input  wire logic [2:0]            proc_req_i,
    input  wire logic [VIB_SERIAL_W-1:0] serial_i,
    input  wire logic [31:0]           svc_mbx_i,
    input  wire logic                  la_irq_flag_i,
    input  wire logic                  proc_irq_flag_i,
    output logic                       la_reset_o,
    output logic                       proc_reset_o,
    output logic                       la_config_start_o,
    output logic                       boot_use_sram_o,
    output logic      [1:0]            boot_sector_o,
    output logic      [1:0]            owner_a_o,
    output logic      [1:0]            owner_b_o,
    output logic      [1:0]            owner_x_o,
    output logic                       mbx_clear_o,
    output logic                       la_irq_o,
    output logic                       proc_mbx_load_o,
    output logic      [31:0]           proc_mbx_data_o,
    output logic                       sram_a_sel_o,
    output logic                       sram_b_sel_o,
    output logic      [VIB_WORD_W-1:0] sram_addr_o
);
    // Register selection looks only at A2, A3, A16, A17 plus the device field
    function automatic logic hit(input logic [23:0] a, input logic [23:0] off);
        hit = (a[VIB_DEV_HI:VIB_DEV_LO] == off[VIB_DEV_HI:VIB_DEV_LO])
            && (a[3:2] == off[3:2]) && (a[17:16] == off[17:16]);
    endfunction : hit

    // Wider decodes for the mailbox locations, which are the exceptions
    function automatic logic hit_full(input logic [23:0] a, input logic [23:0] off);
        hit_full = (a[VIB_DEV_HI:2] == off[VIB_DEV_HI:2]);
    endfunction : hit_full

    logic       iface_sel;
    logic       wr_req;
    logic       wr_rst;
    logic       wr_boot;
    logic       wr_inh;
    logic       wr_clr;
    logic       wr_la_irq;
    logic       wr_pmbx;
    logic       is_mbx_area;

    logic [3:0] req_q;
    logic [1:0] rst_q;
    logic [1:0] sector_q;
    logic       sram_boot_q;
    logic       inhibit_q;
    logic [31:0] rdata_q;
    logic       ack_q;
    logic       cfg_start_q;
    logic       clr_q;
    logic       la_irq_q;
    logic       pmbx_q;
    logic [31:0] pmbx_data_q;
    logic       sram_a_q;
    logic       sram_b_q;
    logic [VIB_WORD_W-1:0] sram_addr_q;

    assign iface_sel   = acc_i && addr_i[VIB_DEV_SEL_BIT];
    assign is_mbx_area = addr_i[17:16] == VIB_OFF_MBX_CLEAR[17:16];
    assign wr_req    = iface_sel && wr_i && !is_mbx_area && hit(addr_i, VIB_OFF_BUS_REQ);
    assign wr_rst    = iface_sel && wr_i && !is_mbx_area && hit(addr_i, VIB_OFF_RESET);
    assign wr_boot   = iface_sel && wr_i && !is_mbx_area && hit(addr_i, VIB_OFF_BOOT);
    assign wr_inh    = iface_sel && wr_i && !is_mbx_area && hit(addr_i, VIB_OFF_INHIBIT);
    assign wr_clr    = iface_sel && wr_i && hit_full(addr_i, VIB_OFF_MBX_CLEAR);
    assign wr_la_irq = iface_sel && wr_i && hit_full(addr_i, VIB_OFF_LA_IRQ);
    assign wr_pmbx   = iface_sel && wr_i && hit_full(addr_i, VIB_OFF_PROC_MBX);

    // Request bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            req_q <= VIB_REQ_RESET;
        else if (wr_req)
            req_q <= {wdata_i[VIB_BIT_REQ_PROC_B], wdata_i[VIB_BIT_REQ_X],
                      wdata_i[VIB_BIT_REQ_B], wdata_i[VIB_BIT_REQ_A]};
    end

    // Resets held asserted out of reset so the devices start quiet
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rst_q <= VIB_RST_RESET;
        else if (wr_rst)
            rst_q <= {wdata_i[VIB_BIT_RST_PROC], wdata_i[VIB_BIT_RST_LA]};
    end

    // Configuration start pulse on the falling edge of the logic array reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_start_q <= 1'b0;
        else
            cfg_start_q <= wr_rst && rst_q[0] && !wdata_i[VIB_BIT_RST_LA];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sector_q    <= VIB_SECTOR_RESET;
            sram_boot_q <= VIB_SRAM_RESET;
        end
        else if (wr_boot)
        begin
            sector_q    <= wdata_i[1:0];
            sram_boot_q <= wdata_i[VIB_BIT_SRAM_BOOT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            inhibit_q <= VIB_INHIBIT_RESET;
        else if (wr_inh)
            inhibit_q <= wdata_i[VIB_BIT_INHIBIT];
    end

    // One-cycle strobes toward the interrupt logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clr_q       <= 1'b0;
            la_irq_q    <= 1'b0;
            pmbx_q      <= 1'b0;
            pmbx_data_q <= 32'h0;
        end
        else
        begin
            clr_q    <= wr_clr;
            la_irq_q <= wr_la_irq;
            pmbx_q   <= wr_pmbx;
            if (wr_pmbx)
                pmbx_data_q <= wdata_i;
        end
    end

    // Arbiters; bus B also carries the host request on behalf of the processor
    vib_arb_if arb_if [3] ();
    logic [1:0] owner_w [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_arb
            assign arb_if[g].host_req         = (g == 0) ? req_q[0] : (g == 1) ? req_q[1] : req_q[2];
            assign arb_if[g].proc_req_by_host = (g == 1) ? req_q[3] : 1'b0;
            assign arb_if[g].la_req           = la_req_i[g];
            assign arb_if[g].proc_req         = proc_req_i[g];
            assign arb_if[g].inhibit          = inhibit_q;
            assign owner_w[g]                 = arb_if[g].owner;
            vib_bus_arbiter u_arb (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .arb   (arb_if[g])
            );
        end
    endgenerate

    // Read mux, registered so the answer comes one cycle after the access
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 32'h0;
            ack_q   <= 1'b0;
        end
        else
        begin
            ack_q   <= iface_sel;
            rdata_q <= 32'h0;
            if (iface_sel && !wr_i)
            begin
                if (hit_full(addr_i, VIB_OFF_SERIAL))
                    rdata_q[VIB_SERIAL_W-1:0] <= serial_i;
                else if (hit_full(addr_i, VIB_OFF_SVC_MBX))
                    rdata_q <= svc_mbx_i;
                else if (is_mbx_area)
                    rdata_q <= 32'h0;
                else if (hit(addr_i, VIB_OFF_BUS_REQ))
                begin
                    // Grant status per bit plus interrupt flags
                    rdata_q[VIB_BIT_REQ_A]    <= owner_w[0] == VIB_OWN_HOST;
                    rdata_q[VIB_BIT_REQ_B]    <= owner_w[1] == VIB_OWN_HOST;
                    rdata_q[VIB_BIT_REQ_X]    <= owner_w[2] == VIB_OWN_HOST;
                    rdata_q[VIB_BIT_REQ_PROC_B] <= owner_w[1] == VIB_OWN_PROC && req_q[3];
                    rdata_q[VIB_BIT_IRQ_LA]   <= la_irq_flag_i;
                    rdata_q[VIB_BIT_IRQ_PROC] <= proc_irq_flag_i;
                end
                else if (hit(addr_i, VIB_OFF_BOOT))
                begin
                    rdata_q[1:0]               <= sector_q;
                    rdata_q[VIB_BIT_SRAM_BOOT] <= sram_boot_q;
                end
                else if (hit(addr_i, VIB_OFF_OWNER_A))
                    rdata_q[1:0] <= owner_w[0];
                else if (hit(addr_i, VIB_OFF_OWNER_B))
                    rdata_q[1:0] <= owner_w[1];
                else if (hit(addr_i, VIB_OFF_OWNER_X))
                    rdata_q[1:0] <= owner_w[2];
            end
        end
    end

    // SRAM window decode, bit 23 clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sram_a_q    <= 1'b0;
            sram_b_q    <= 1'b0;
            sram_addr_q <= '0;
        end
        else
        begin
            sram_a_q <= acc_i && !addr_i[VIB_DEV_SEL_BIT] && (addr_i[22:21] == VIB_DEV_SRAM_A0[1:0]);
            sram_b_q <= acc_i && !addr_i[VIB_DEV_SEL_BIT] && (addr_i[22:21] == VIB_DEV_SRAM_A1[1:0]);
            sram_addr_q <= addr_i[VIB_WORD_W-1:0];
        end
    end

    assign rdata_o           = rdata_q;
    assign ack_o             = ack_q;
    assign la_reset_o        = rst_q[0];
    assign proc_reset_o      = rst_q[1];
    assign la_config_start_o = cfg_start_q;
    assign boot_use_sram_o   = sram_boot_q;
    assign boot_sector_o     = sector_q;
    assign owner_a_o         = owner_w[0];
    assign owner_b_o         = owner_w[1];
    assign owner_x_o         = owner_w[2];
    assign mbx_clear_o       = clr_q;
    assign la_irq_o          = la_irq_q;
    assign proc_mbx_load_o   = pmbx_q;
    assign proc_mbx_data_o   = pmbx_data_q;
    assign sram_a_sel_o      = sram_a_q;
    assign sram_b_sel_o      = sram_b_q;
    assign sram_addr_o       = sram_addr_q;

    a_req_write_all: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_req |=> req_q == {$past(wdata_i[17]), $past(wdata_i[16]), $past(wdata_i[1]), $past(wdata_i[0])})
        else $error("request bits not updated together");
    a_reset_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_rst |=> la_reset_o == $past(wdata_i[0]) && proc_reset_o == $past(wdata_i[1]))
        else $error("reset bits not taken from write");
    a_cfg_on_release: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(la_reset_o) |-> la_config_start_o)
        else $error("no configuration start on reset release");
    a_no_bit23_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_i && !addr_i[23]) |=> !ack_o)
        else $error("interface answered without bit 23");
    a_serial_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_i && !wr_i && addr_i == VIB_OFF_SERIAL) |=> rdata_o[31:11] == 21'h0)
        else $error("serial upper bits not zero");
    // A lone clear write must give exactly one strobe cycle
    sequence s_clr_single;
        wr_clr ##1 !wr_clr;
    endsequence
    sequence s_clr_pulse;
        mbx_clear_o ##1 !mbx_clear_o;
    endsequence
    a_clear_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
        s_clr_single |-> s_clr_pulse)
        else $error("mailbox clear strobe wrong");
endmodule : vib_reg_bank
`default_nettype wire

// ---- vib_onboard_model.sv ----
// Behavioural model of the on-board logic array and processor facing the bank
`timescale 1ns/1ps
`default_nettype none
module vib_onboard_model
    import vib_pkg::*;
#(
    parameter logic [VIB_SERIAL_W-1:0] SERIAL_NUM = 11'h2C5  // Arbitrary board number
)
(
    input  wire logic [2:0]              la_want_i,
    input  wire logic [2:0]              proc_want_i,
    input  wire logic [1:0]              irq_i,
    input  wire logic [31:0]             mbx_i,
    input  wire logic                    la_reset_i,
    input  wire logic                    proc_reset_i,
    output logic      [2:0]              la_req_o,
    output logic      [2:0]              proc_req_o,
    output logic      [VIB_SERIAL_W-1:0] serial_o,
    output logic      [31:0]             mbx_o,
    output logic                         la_irq_o,
    output logic                         proc_irq_o
);
    // A device held in reset cannot ask for a bus; an unknown reset counts as held
    assign la_req_o   = (la_reset_i === 1'b0) ? la_want_i : 3'h0;
    assign proc_req_o = (proc_reset_i === 1'b0) ? proc_want_i : 3'h0;
    assign serial_o   = SERIAL_NUM;
    assign mbx_o      = mbx_i;
    assign la_irq_o   = irq_i[0];
    assign proc_irq_o = irq_i[1];
endmodule : vib_onboard_model
`default_nettype wire

// ---- tb_vib_reg_bank.sv ----
// Self-checking testbench for the VME interface register bank
`timescale 1ns/1ps
`default_nettype none
module tb_vib_reg_bank
    import vib_pkg::*;
;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    acc_i = 1'b0;
    logic                    wr_i = 1'b0;
    logic [VIB_LADDR_W-1:0]  addr_i = '0;
    logic [31:0]             wdata_i = '0;
    logic [2:0]              la_want = 3'h0;
    logic [2:0]              proc_want = 3'h0;
    logic [1:0]              irq_want = 2'h0;
    logic [31:0]             mbx_want = 32'h0;
    logic [31:0]             rdata_o, svc_mbx_i, proc_mbx_data_o, rdv;
    logic [2:0]              la_req_i, proc_req_i;
    logic [1:0]              owner_a_o, owner_b_o, owner_x_o, boot_sector_o;
    logic [VIB_SERIAL_W-1:0] serial_i;
    logic [VIB_WORD_W-1:0]   sram_addr_o;
    logic                    ack_o, la_irq_flag_i, proc_irq_flag_i, la_reset_o, proc_reset_o, akv;
    logic                    la_config_start_o, boot_use_sram_o, mbx_clear_o, la_irq_o, proc_mbx_load_o;
    logic                    sram_a_sel_o, sram_b_sel_o;
    int                      num_errors = 0;
    int                      n_checks = 0;

    vib_reg_bank uut (
        .clk_i(clk_i), .rst_i(rst_i), .acc_i(acc_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .ack_o(ack_o), .la_req_i(la_req_i), .proc_req_i(proc_req_i), .serial_i(serial_i),
        .svc_mbx_i(svc_mbx_i), .la_irq_flag_i(la_irq_flag_i), .proc_irq_flag_i(proc_irq_flag_i),
        .la_reset_o(la_reset_o), .proc_reset_o(proc_reset_o), .la_config_start_o(la_config_start_o),
        .boot_use_sram_o(boot_use_sram_o), .boot_sector_o(boot_sector_o), .owner_a_o(owner_a_o),
        .owner_b_o(owner_b_o), .owner_x_o(owner_x_o), .mbx_clear_o(mbx_clear_o), .la_irq_o(la_irq_o),
        .proc_mbx_load_o(proc_mbx_load_o), .proc_mbx_data_o(proc_mbx_data_o), .sram_a_sel_o(sram_a_sel_o),
        .sram_b_sel_o(sram_b_sel_o), .sram_addr_o(sram_addr_o));

    vib_onboard_model partner (
        .la_want_i(la_want), .proc_want_i(proc_want), .irq_i(irq_want), .mbx_i(mbx_want),
        .la_reset_i(la_reset_o), .proc_reset_i(proc_reset_o), .la_req_o(la_req_i), .proc_req_o(proc_req_i),
        .serial_o(serial_i), .mbx_o(svc_mbx_i), .la_irq_o(la_irq_flag_i), .proc_irq_o(proc_irq_flag_i));

    always #4 clk_i = ~clk_i;

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Request held from one falling edge to the next, so the taking edge sees it settled
    task automatic access(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(negedge clk_i);
        acc_i = 1'b1;
        wr_i = w;
        // Host strips slot and don't-care bits; only the local part reaches the bank
        addr_i = a;
        wdata_i = d;
        @(negedge clk_i);
        acc_i = 1'b0;
        rdv = rdata_o;
        akv = ack_o;
    endtask : access

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        access(1'b1, a, d);
        check(32'(akv), 32'h1);
    endtask : wr

    task automatic rd(input logic [23:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(32'(akv), 32'h1);
        check(rdv, exp);
    endtask : rd

    // Grants take a few cycles through the arbiter, so poll under a bound
    task automatic own_is(input int b, input logic [1:0] e);
        logic [1:0] o;
        for (int i = 0; i < 8; i++)
        begin
            o = (b == 0) ? owner_a_o : (b == 1) ? owner_b_o : owner_x_o;
            if (o === e)
                break;
            @(negedge clk_i);
        end
        check(32'(o), 32'(e));
    endtask : own_is

    function automatic logic [31:0] req_word(input logic [3:0] own, input logic [1:0] irq);
        return {12'h0, irq, own[3:2], 14'h0, own[1:0]};
    endfunction : req_word

    initial
    begin
        logic [31:0] v;
        logic [23:0] a;
        void'($urandom(32'h9b3bae66));
        irq_want = 2'($urandom);
        mbx_want = $urandom;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        check(32'({la_reset_o, proc_reset_o, owner_a_o, owner_b_o, owner_x_o}), 32'hC0);
        for (int i = 0; i < 5; i++)
        begin
            v = (i < 4) ? 32'(i) : (32'h00010000 | 32'($urandom_range(3)));
            wr((i == 3) ? (VIB_OFF_BOOT | 24'h10) : VIB_OFF_BOOT, v | ($urandom & 32'hFFFCFFFC));
            check(32'({boot_use_sram_o, boot_sector_o}), 32'({v[16], v[1:0]}));
            rd(VIB_OFF_BOOT, v);
        end
        wr(VIB_OFF_RESET, 32'h1);
        check(32'({la_reset_o, proc_reset_o, la_config_start_o}), 32'h4);
        wr(VIB_OFF_RESET, 32'h0);
        check(32'({la_reset_o, proc_reset_o, la_config_start_o, boot_use_sram_o}), 32'h3);
        @(negedge clk_i);
        check(32'(la_config_start_o), 32'h0);
        rd(VIB_OFF_RESET, 32'h0);
        wr(VIB_OFF_BUS_REQ, 32'h00010003);
        for (int b = 0; b < 3; b++)
            own_is(b, VIB_OWN_HOST);
        rd(VIB_OFF_BUS_REQ, req_word(4'h7, irq_want));
        rd(VIB_OFF_OWNER_B, 32'h1);
        wr(VIB_OFF_BUS_REQ, 32'h00000001);
        own_is(1, VIB_OWN_FREE);
        own_is(2, VIB_OWN_FREE);
        own_is(0, VIB_OWN_HOST);
        la_want = 3'h3;
        proc_want = 3'h6;
        own_is(1, VIB_OWN_LA);
        own_is(2, VIB_OWN_PROC);
        rd(VIB_OFF_OWNER_X, 32'h3);
        wr(VIB_OFF_BUS_REQ, 32'h00000003);
        repeat (4) @(negedge clk_i);
        own_is(1, VIB_OWN_LA);
        wr(VIB_OFF_INHIBIT, 32'h1);
        own_is(1, VIB_OWN_HOST);
        own_is(2, VIB_OWN_FREE);
        rd(VIB_OFF_INHIBIT, 32'h0);
        wr(VIB_OFF_BUS_REQ, 32'h00020001);
        own_is(1, VIB_OWN_PROC);
        rd(VIB_OFF_BUS_REQ, req_word(4'h9, irq_want));
        wr(VIB_OFF_BUS_REQ, 32'h0);
        own_is(0, VIB_OWN_FREE);
        own_is(1, VIB_OWN_FREE);
        wr(VIB_OFF_INHIBIT, 32'h0);
        own_is(0, VIB_OWN_LA);
        own_is(1, VIB_OWN_LA);
        own_is(2, VIB_OWN_PROC);
        la_want = 3'h0;
        proc_want = 3'h0;
        for (int b = 0; b < 3; b++)
            own_is(b, VIB_OWN_FREE);
        for (int i = 0; i < 3; i++)
        begin
            v = $urandom;
            wr((i == 0) ? VIB_OFF_MBX_CLEAR : (i == 1) ? VIB_OFF_LA_IRQ : VIB_OFF_PROC_MBX, v);
            check(32'({mbx_clear_o, la_irq_o, proc_mbx_load_o}), 32'(3'h4 >> i));
            @(negedge clk_i);
            check(32'({mbx_clear_o, la_irq_o, proc_mbx_load_o}), 32'h0);
        end
        check(proc_mbx_data_o, v);
        wr(VIB_OFF_SERIAL, 32'hFFFFFFFF);
        rd(VIB_OFF_SERIAL, 32'(serial_i));
        rd(VIB_OFF_SVC_MBX, mbx_want);
        rd(24'h81000C, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 0) ? 24'h1FFFFC : (i == 1) ? 24'h200000 : ({1'b0, 23'($urandom)} & 24'h7FFFFC);
            access(1'($urandom), a, $urandom);
            check(32'(akv), 32'h0);
            check(32'({sram_a_sel_o, sram_b_sel_o}), (a[22:21] == 2'h0) ? 32'h2 : (a[22:21] == 2'h1) ? 32'h1 : 32'h0);
            if (a[22] == 1'b0)
                check(32'(sram_addr_o), 32'(a[20:0]));
        end
        end_of_test();
    end

    initial
    begin
        #(8 * 20000);
        num_errors++;
        end_of_test();
    end
endmodule : tb_vib_reg_bank
`default_nettype wire
